// >>> hw/ssdsc_pkg.sv
package ssdsc_pkg;

	localparam int          FRAME_BITS        = 8;
	localparam int          CHANNELS          = 6;
	localparam int          CNT_BITS          = 3;

	// command byte layout: write flag, address bits, data field
	localparam int          CMD_WRITE_BIT     = 7;
	localparam int          CMD_ADDR_MSB      = 6;
	localparam int          CMD_ADDR_LSB      = 4;
	localparam int          CTRL_SEL_MSB      = 2;
	localparam int          CTRL_SEL_LSB      = 0;
	localparam int          CTRL_BYPASS_BIT   = 3;
	localparam logic [2:0]  ADDR_DIAG_CTRL    = 3'h7;

	// standard diagnosis word layout
	localparam int          DIAG_LOW_SIDE_BIT = 6;
	localparam logic        DIAG_TOP_BIT_VAL  = 1'b0;
	localparam logic        CTRL_READ_FLAG    = 1'b0;

	// sense select codes
	localparam logic [2:0]  SENSE_LAST_CH     = 3'h5;
	localparam logic [2:0]  SENSE_OFF         = 3'h6;
	localparam logic [2:0]  SENSE_STANDBY     = 3'h7;

	// reset values
	localparam logic [2:0]  SENSE_SEL_RST     = 3'h7;
	localparam logic        XFER_ERR_RST      = 1'b0;
	localparam logic [15:0] PIN_SYNC_RST      = 16'h8000;
	localparam logic [10:0] LINK_SYNC_RST     = 11'h000;

	typedef enum logic {
		ST_IDLE   = 1'b0,
		ST_ACTIVE = 1'b1
	} ssdsc_state_t;

	typedef enum logic {
		RESP_DIAG = 1'b0,
		RESP_CTRL = 1'b1
	} ssdsc_resp_t;

endpackage : ssdsc_pkg

// >>> hw/ssdsc_sync.sv
`timescale 1ns/1ps
module ssdsc_sync #(
	parameter int               WIDTH   = 1,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	input  wire logic             i_clk,   // destination clock
	input  wire logic             i_rst,   // synchronous reset, high
	input  wire logic [WIDTH-1:0] i_async, // foreign-domain level
	output logic      [WIDTH-1:0] o_sync   // two-flop synchronised level
);

	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] meta_d;
	logic [WIDTH-1:0] sync_q;
	logic [WIDTH-1:0] sync_d;

	// the first stage feeds only the second stage
	always_comb begin
		meta_d = i_async;
		sync_d = meta_q;
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			meta_q <= RST_VAL;
			sync_q <= RST_VAL;
		end else begin
			meta_q <= meta_d;
			sync_q <= sync_d;
		end
	end

	assign o_sync = sync_q;

endmodule : ssdsc_sync

// >>> hw/ssdsc_link.sv
`timescale 1ns/1ps
module ssdsc_link (
	input  wire logic       i_sclk,     // serial clock from the master
	input  wire logic       i_clr,      // async clear, held while deselected
	input  wire logic       i_si,       // serial input pin
	input  wire logic [7:0] i_tx_word,  // answer word, static during a frame
	output logic      [7:0] o_rx,       // last eight received bits
	output logic            o_so,       // bit shifted out after a rising edge
	output logic            o_rose,     // a rising edge has occurred
	output logic            o_frame_ok  // falls are a nonzero multiple of 8
);

	logic [2:0] cnt_q;
	logic [2:0] cnt_d;
	logic       any_q;
	logic       any_d;
	logic       full_q;
	logic       full_d;
	logic [7:0] rx_q;
	logic [7:0] rx_d;
	logic       so_q;
	logic       so_d;
	logic       rose_q;
	logic       rose_d;

	always_comb begin
		cnt_d  = cnt_q + 3'h1;
		any_d  = 1'b1;
		full_d = full_q | (cnt_q == 3'h7);
		rx_d   = {rx_q[6:0], i_si};
	end

	always_ff @(negedge i_sclk or posedge i_clr) begin
		if (i_clr) begin
			cnt_q  <= 3'h0;
			any_q  <= 1'b0;
			full_q <= 1'b0;
			rx_q   <= 8'h00;
		end else begin
			cnt_q  <= cnt_d;
			any_q  <= any_d;
			full_q <= full_d;
			rx_q   <= rx_d;
		end
	end

	// the loaded word leaves msb first; once it is gone, received bits
	// come out eight clocks late, which is what a chain needs
	always_comb begin
		so_d   = full_q ? rx_q[7] : i_tx_word[~cnt_q];
		rose_d = 1'b1;
	end

	always_ff @(posedge i_sclk or posedge i_clr) begin
		if (i_clr) begin
			so_q   <= 1'b0;
			rose_q <= 1'b0;
		end else begin
			so_q   <= so_d;
			rose_q <= rose_d;
		end
	end

	assign o_rx       = rx_q;
	assign o_so       = so_q;
	assign o_rose     = rose_q;
	assign o_frame_ok = any_q & (cnt_q == 3'h0);

endmodule : ssdsc_link

// >>> hw/ssdsc_top.sv
// How it works
// - deselected: ignore clock and input, output floats
// - sample input on falling, shift out on rising
// - act only on nonzero multiple of eight clocks
// - bad count sets error flag, discards command
// - selection loads answer word into shift path
// - before first rise output shows error OR input
// - valid deselect writes data into addressed register
// - msb first, control bits ahead of data
// - received bits pass through to the output
// - control register address 111, select bits 2:0
// - channel on: codes 0-5 route, 6 floats
// - channel off floats; code 7 is stand-by
// - read bit 3 reports bypass comparator, 0 in stand-by (code 7)
// - diagnosis word: 0, low-side flag, channel errors
`timescale 1ns/1ps
module ssdsc_top (
	input  wire logic       i_mclk,                     // system clock, 50 MHz
	input  wire logic       i_sys_rst,                  // synchronous reset, high
	input  wire logic       i_spi_sclk,                 // serial clock pin
	input  wire logic       i_cs_n,                     // chip select pin, low active
	input  wire logic       i_si,                       // serial input pin
	output logic            o_so,                       // serial output level
	output logic            o_so_oe_n,                  // serial output enable, low drives
	input  wire logic [5:0] i_channel_output_on,        // per-channel output state
	input  wire logic [5:0] i_channel_error_flag,       // per-channel failure flags
	input  wire logic       i_low_side_indication_flag, // low-side indication status
	input  wire logic       i_bypass_monitor,           // bypass comparator output
	output logic [2:0]      o_sense_channel,            // channel routed to the sense pin
	output logic            o_sense_output_pin_en,      // sense pin driven when high
	output logic            o_sense_standby,            // sense block in stand-by
	output logic            o_transmission_error_flag   // error flag state
);

	logic [15:0]              pin_s;
	logic                     cs_n_s;
	logic                     si_s;
	logic                     bypass_s;
	logic                     low_side_s;
	logic [5:0]               err_s;
	logic [5:0]               chan_on_s;

	logic [7:0]               link_rx;
	logic                     link_so;
	logic                     link_rose;
	logic                     link_ok;
	logic [10:0]              link_s;
	logic [7:0]               rx_s;
	logic                     so_link_s;
	logic                     rose_s;
	logic                     frame_ok_s;

	ssdsc_pkg::ssdsc_state_t  st_q;
	ssdsc_pkg::ssdsc_state_t  st_d;
	ssdsc_pkg::ssdsc_resp_t   resp_q;
	ssdsc_pkg::ssdsc_resp_t   resp_d;
	logic [7:0]               tx_q;
	logic [7:0]               tx_d;
	logic                     xfer_err_q;
	logic                     xfer_err_d;
	logic [2:0]               sense_sel_q;
	logic [2:0]               sense_sel_d;
	logic                     link_clr_q;
	logic                     link_clr_d;
	logic                     so_q;
	logic                     so_d;
	logic                     so_oe_n_q;
	logic                     so_oe_n_d;
	logic [2:0]               sense_ch_q;
	logic [2:0]               sense_ch_d;
	logic                     sense_en_q;
	logic                     sense_en_d;
	logic                     standby_q;
	logic                     standby_d;

	logic                     sel_fall;
	logic                     sel_rise;
	logic                     cmd_write;
	logic [2:0]               cmd_addr;
	logic                     bypass_bit;
	logic [7:0]               diag_word;
	logic [7:0]               ctrl_word;
	logic [7:0]               chan_pad;

	ssdsc_sync #(
		.WIDTH   (16),
		.RST_VAL (ssdsc_pkg::PIN_SYNC_RST)
	) u_pin_sync (
		.i_clk   (i_mclk),
		.i_rst   (i_sys_rst),
		.i_async ({i_cs_n, i_si, i_bypass_monitor, i_low_side_indication_flag,
			i_channel_error_flag, i_channel_output_on}),
		.o_sync  (pin_s)
	);

	assign cs_n_s    = pin_s[15];
	assign si_s      = pin_s[14];
	assign bypass_s  = pin_s[13];
	assign low_side_s = pin_s[12];
	assign err_s     = pin_s[11:6];
	assign chan_on_s = pin_s[5:0];

	// the link runs on the serial clock alone and is held clear whenever
	// the device is deselected, so stray clocks then do nothing
	ssdsc_link u_link (
		.i_sclk     (i_spi_sclk),
		.i_clr      (link_clr_q),
		.i_si       (i_si),
		.i_tx_word  (tx_q),
		.o_rx       (link_rx),
		.o_so       (link_so),
		.o_rose     (link_rose),
		.o_frame_ok (link_ok)
	);

	// link results are static once the clock has stopped, so a plain
	// two-flop copy is safe to read at deselect
	ssdsc_sync #(
		.WIDTH   (11),
		.RST_VAL (ssdsc_pkg::LINK_SYNC_RST)
	) u_link_sync (
		.i_clk   (i_mclk),
		.i_rst   (i_sys_rst),
		.i_async ({link_ok, link_rose, link_so, link_rx}),
		.o_sync  (link_s)
	);

	assign frame_ok_s = link_s[10];
	assign rose_s     = link_s[9];
	assign so_link_s  = link_s[8];
	assign rx_s       = link_s[7:0];

	assign sel_fall   = (st_q == ssdsc_pkg::ST_IDLE) & ~cs_n_s;
	assign sel_rise   = (st_q == ssdsc_pkg::ST_ACTIVE) & cs_n_s;
	assign cmd_write  = rx_s[ssdsc_pkg::CMD_WRITE_BIT];
	assign cmd_addr   = rx_s[ssdsc_pkg::CMD_ADDR_MSB:ssdsc_pkg::CMD_ADDR_LSB];
	assign bypass_bit = bypass_s & (sense_sel_q != ssdsc_pkg::SENSE_STANDBY);
	assign diag_word  = {ssdsc_pkg::DIAG_TOP_BIT_VAL, low_side_s, err_s};
	assign ctrl_word  = {ssdsc_pkg::CTRL_READ_FLAG, ssdsc_pkg::ADDR_DIAG_CTRL,
		bypass_bit, sense_sel_q};
	assign chan_pad   = {2'h0, chan_on_s};

	// frame sequencing and register updates
	always_comb begin
		st_d        = st_q;
		resp_d      = resp_q;
		tx_d        = tx_q;
		xfer_err_d  = xfer_err_q;
		sense_sel_d = sense_sel_q;
		link_clr_d  = link_clr_q;
		if (sel_fall) begin
			st_d       = ssdsc_pkg::ST_ACTIVE;
			link_clr_d = 1'b0;
			tx_d       = (resp_q == ssdsc_pkg::RESP_CTRL) ? ctrl_word : diag_word;
		end else if (sel_rise) begin
			// clock is low here, so the link is already at rest
			st_d       = ssdsc_pkg::ST_IDLE;
			link_clr_d = 1'b1;
			if (frame_ok_s) begin
				xfer_err_d = 1'b0;
				resp_d = ssdsc_pkg::RESP_DIAG;
				if (cmd_addr == ssdsc_pkg::ADDR_DIAG_CTRL) begin
					if (cmd_write) begin
						sense_sel_d = rx_s[ssdsc_pkg::CTRL_SEL_MSB:ssdsc_pkg::CTRL_SEL_LSB];
					end else begin
						resp_d = ssdsc_pkg::RESP_CTRL;
					end
				end
			end else begin
				xfer_err_d = 1'b1;
			end
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			st_q        <= ssdsc_pkg::ST_IDLE;
			resp_q      <= ssdsc_pkg::RESP_DIAG;
			tx_q        <= 8'h00;
			xfer_err_q  <= ssdsc_pkg::XFER_ERR_RST;
			sense_sel_q <= ssdsc_pkg::SENSE_SEL_RST;
			link_clr_q  <= 1'b1;
		end else begin
			st_q        <= st_d;
			resp_q      <= resp_d;
			tx_q        <= tx_d;
			xfer_err_q  <= xfer_err_d;
			sense_sel_q <= sense_sel_d;
			link_clr_q  <= link_clr_d;
		end
	end

	// serial output pin; the or with the input lets a chain report an error
	// from any device before the first rising clock
	always_comb begin
		so_oe_n_d = cs_n_s;
		so_d      = rose_s ? so_link_s : (xfer_err_q | si_s);
		if (cs_n_s) begin
			so_d = 1'b0;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			so_q      <= 1'b0;
			so_oe_n_q <= 1'b1;
		end else begin
			so_q      <= so_d;
			so_oe_n_q <= so_oe_n_d;
		end
	end

	// sense multiplexer controls
	always_comb begin
		sense_ch_d = sense_sel_q;
		sense_en_d = (sense_sel_q <= ssdsc_pkg::SENSE_LAST_CH)
			& chan_pad[sense_sel_q];
		standby_d  = (sense_sel_q == ssdsc_pkg::SENSE_STANDBY);
	end

	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			sense_ch_q <= ssdsc_pkg::SENSE_SEL_RST;
			sense_en_q <= 1'b0;
			standby_q  <= 1'b1;
		end else begin
			sense_ch_q <= sense_ch_d;
			sense_en_q <= sense_en_d;
			standby_q  <= standby_d;
		end
	end

	assign o_so                      = so_q;
	assign o_so_oe_n                 = so_oe_n_q;
	assign o_sense_channel           = sense_ch_q;
	assign o_sense_output_pin_en     = sense_en_q;
	assign o_sense_standby           = standby_q;
	assign o_transmission_error_flag = xfer_err_q;

	default clocking cb_m @(posedge i_mclk);
	endclocking
	default disable iff (i_sys_rst);

	sequence s_end_good;
		sel_rise && frame_ok_s;
	endsequence

	sequence s_end_bad;
		sel_rise && !frame_ok_s;
	endsequence

	sequence s_write_ctrl;
		s_end_good ##0 (cmd_write && cmd_addr == ssdsc_pkg::ADDR_DIAG_CTRL);
	endsequence

	a_idle_float: assert property (cs_n_s ##1 cs_n_s |-> o_so_oe_n && link_clr_q)
		else $error("serial output driven or link live while deselected");

	a_select_drive: assert property (!cs_n_s |=> !o_so_oe_n)
		else $error("serial output not driven while selected");

	a_bad_sets_err: assert property (s_end_bad |=> xfer_err_q ##1 xfer_err_q)
		else $error("bad frame length did not set error flag");

	a_bad_keeps_sel: assert property (s_end_bad |=> sense_sel_q == $past(sense_sel_q)
		&& resp_q == $past(resp_q))
		else $error("bad frame changed a register");

	a_write_takes: assert property (s_write_ctrl |=> sense_sel_q == $past(rx_s[2:0])
		&& !xfer_err_q)
		else $error("valid write did not reach the control register");

	a_load_word: assert property (sel_fall |=> tx_q == ($past(resp_q) == ssdsc_pkg::RESP_CTRL
		? $past(ctrl_word) : $past(diag_word)))
		else $error("answer word not loaded at select");

	a_first_bit: assert property (!cs_n_s && !rose_s |=> o_so == $past(xfer_err_q | si_s))
		else $error("first output level is not error or input");

	a_diag_top: assert property (sel_fall && resp_q == ssdsc_pkg::RESP_DIAG
		|=> tx_q[7] == 1'b0 && tx_q[5:0] == $past(err_s))
		else $error("diagnosis word layout wrong");

	a_bypass_bit: assert property (sel_fall && resp_q == ssdsc_pkg::RESP_CTRL
		|=> tx_q[3] == $past(bypass_s && sense_sel_q != ssdsc_pkg::SENSE_STANDBY))
		else $error("bypass bit not reported");

	a_route_off: assert property ((sense_sel_q > ssdsc_pkg::SENSE_LAST_CH
		|| !chan_pad[sense_sel_q]) |=> !o_sense_output_pin_en)
		else $error("sense pin driven while it must float");

	a_route_on: assert property ((sense_sel_q <= ssdsc_pkg::SENSE_LAST_CH
		&& chan_pad[sense_sel_q]) |=> o_sense_output_pin_en
		&& o_sense_channel == $past(sense_sel_q))
		else $error("active channel not routed to sense pin");

	a_standby: assert property (sense_sel_q == ssdsc_pkg::SENSE_STANDBY
		|=> o_sense_standby && !o_sense_output_pin_en)
		else $error("stand-by code not honoured");

endmodule : ssdsc_top

// >>> tb/ssdsc_master.sv
`timescale 1ns/1ps
module ssdsc_master (
	input  wire logic i_mclk,    // system clock, aligns the start of each frame
	input  wire logic i_so,      // device serial output level
	input  wire logic i_so_oe_n, // device output enable, low drives
	output logic      o_sclk,    // serial clock, low outside frames except while noise toggles it
	output logic      o_cs_n,    // chip select, low active
	output logic      o_si       // serial data to the device
);
	// a released line reads as the inverse, so a stale level never passes
	function automatic logic line(input logic v, input logic oe_n);
		return oe_n ? ~v : v;
	endfunction : line

	initial begin
		o_sclk = 1'b0;
		o_cs_n = 1'b1;
		o_si   = 1'b0;
	end

	task automatic xfer(input int n, input logic [15:0] tx, output logic first,
			output logic [15:0] rx);
		rx = '0;
		@(negedge i_mclk);
		#3 o_cs_n = 1'b0;
		// leading bit already on the input so the pre-clock or sees it
		o_si = tx[n - 1];
		#1000 first = line(i_so, i_so_oe_n);
		for (int i = n - 1; i >= 0; i--) begin
			o_si = tx[i];
			#40 o_sclk = 1'b1;
			#80 o_sclk = 1'b0;
			#40 rx[i] = line(i_so, i_so_oe_n);
		end
		#1000 o_cs_n = 1'b1;
		o_si = 1'b0;
		#1000;
	endtask : xfer

	// clock and data toggled while deselected; an odd count would spoil
	// the next frame's length if the device counted it
	task automatic noise();
		@(negedge i_mclk);
		for (int i = 0; i < 5; i++) begin
			#80 o_sclk = 1'b1;
			o_si = ~o_si;
			#80 o_sclk = 1'b0;
		end
		o_si = 1'b0;
		#1000;
	endtask : noise
endmodule : ssdsc_master

// >>> tb/tb.sv
`timescale 1ns/1ps
module tb;
	logic       mclk, rst, sclk, cs_n, si, so, so_oe_n;
	logic [5:0] on, errf;
	logic       low_side, bp, sense_en, standby, xfer_err;
	logic [2:0] sense_ch;
	int         err_count, tests_run;
	logic [2:0] m_sel;
	logic       m_xfer_err, m_ctrl;

	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end

	ssdsc_master i_master (
		.i_mclk    (mclk),
		.i_so      (so),
		.i_so_oe_n (so_oe_n),
		.o_sclk    (sclk),
		.o_cs_n    (cs_n),
		.o_si      (si)
	);

	ssdsc_top i_dut (
		.i_mclk                     (mclk),
		.i_sys_rst                  (rst),
		.i_spi_sclk                 (sclk),
		.i_cs_n                     (cs_n),
		.i_si                       (si),
		.o_so                       (so),
		.o_so_oe_n                  (so_oe_n),
		.i_channel_output_on        (on),
		.i_channel_error_flag       (errf),
		.i_low_side_indication_flag (low_side),
		.i_bypass_monitor           (bp),
		.o_sense_channel            (sense_ch),
		.o_sense_output_pin_en      (sense_en),
		.o_sense_standby            (standby),
		.o_transmission_error_flag  (xfer_err)
	);

	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		tests_run++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	task automatic final_report();
		$display("checks %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : final_report

	task automatic outs();
		chk("oe_n", 16'h0001, 16'(so_oe_n));
		chk("so", 16'h0000, 16'(so));
		chk("xfer_err", 16'(m_xfer_err), 16'(xfer_err));
		chk("sel", 16'(m_sel), 16'(sense_ch));
		chk("en", 16'((m_sel < 3'h6) && on[m_sel]), 16'(sense_en));
		chk("standby", 16'(m_sel == 3'h7), 16'(standby));
	endtask : outs

	// one frame, answer and outputs checked against the model
	task automatic frame(input int n, input logic [15:0] tx);
		logic        first;
		logic [15:0] rx;
		logic [7:0]  ans;
		logic [15:0] mask;
		ans = m_ctrl ? {1'b0, 3'h7, (m_sel != 3'h7) & bp, m_sel} : {1'b0, low_side, errf};
		i_master.xfer(n, tx, first, rx);
		chk("first", 16'(m_xfer_err | tx[n - 1]), 16'(first));
		if (n < 8) begin
			chk("rx", 16'(ans >> (8 - n)), rx);
		end else begin
			chk("rx", 16'(ans), rx >> (n - 8));
		end
		if (n > 8) begin
			mask = 16'((1 << (n - 8)) - 1);
			chk("pass", (tx >> 8) & mask, rx & mask);
		end
		if (n % 8 == 0) begin
			m_xfer_err = 1'b0;
			if (tx[7] && tx[6:4] == 3'h7) m_sel = tx[2:0];
			m_ctrl = !tx[7] && tx[6:4] == 3'h7;
		end else begin
			m_xfer_err = 1'b1;
		end
		outs();
	endtask : frame

	initial begin
		rst = 1'b1;
		on = 6'h2a;
		errf = 6'h15;
		low_side = 1'b1;
		bp = 1'b1;
		err_count = 0;
		tests_run = 0;
		m_sel = 3'h7;
		m_xfer_err = 1'b0;
		m_ctrl = 1'b0;
		repeat (10) @(negedge mclk);
		rst = 1'b0;
		repeat (5) @(negedge mclk);
		outs();
		frame(8, 16'h0070);
		frame(8, 16'h0000);
		for (int p = 0; p < 2; p++) begin
			@(negedge mclk);
			on = p ? 6'h15 : 6'h2a;
			for (int c = 0; c < 8; c++) frame(8, 16'(8'hf0 | c));
		end
		frame(8, 16'h00f2);
		frame(8, 16'h0070);
		frame(8, 16'h0011);
		@(negedge mclk);
		bp = 1'b0;
		low_side = 1'b0;
		errf = 6'h2a;
		frame(8, 16'h0070);
		frame(7, 16'h0075);
		frame(8, 16'h00f5);
		frame(9, 16'h01f6);
		frame(16, 16'h55f4);
		// sense select must survive traffic seen while deselected
		i_master.noise();
		outs();
		frame(8, 16'h0070);
		final_report();
	end

	initial begin
		#500000;
		err_count++;
		final_report();
	end
endmodule : tb
